// File: pkg/alc_pkg.sv
/*
 conversion control constants for the low-power converter sequencer.
 assumes a single 20 MHz clock; converter clock arrives as a one-cycle tick.
*/
// What this block does
// R1: short sampling window lasts three and a half converter-clock cycles.
// R2: long-sample select stretches the sampling window to twenty-three and a half cycles.
// R3: results are 8 or 10 bits; 10-bit mode spans codes 0 to 1023.
// R4: interrupt request rises with the done flag only if completion interrupt enabled.
// R5: done flag sets after every conversion regardless of interrupt enable.
// R6: in wait mode conversions and interrupts continue unchanged.
// R7: channel field all ones shuts the converter down into low power.
// R8: stop with async clock disabled aborts conversion and enters low power.
// R9: after such a stop, conversions resume only on a control register write.
// R10: abort leaves result registers holding the last completed conversion.
// R11: stop with async clock enabled keeps normal conversion and interrupts.
// R12: single mode returns to low power after each completed conversion.
// R13: hardware trigger mode waits low-power for trigger, converts once (keeps converting if continuous set), interrupts.
// R14: software clears continuous bit before stop if no wakeup is wanted.
// R15: control write or low result read clears the done flag.
// R16: control write aborts and restarts unless channel field is all ones or hardware trigger mode is selected.
// R17: continuous mode restarts after each completed conversion until aborted.
// R18: interrupt request stays high until the done flag is cleared.
package alc_pkg;
	localparam int CHAN_W = 5;
	localparam logic [4:0] CHAN_OFF = 5'h1F;
	localparam int RES_W = 10;
	localparam int RES8_W = 8;
	// sample windows in half converter cycles: 3.5 and 23.5 cycles
	localparam int SHORT_SAMPLE_HALF = 7;
	localparam int LONG_SAMPLE_HALF = 47;
	// successive approximation steps per mode
	localparam int STEPS_10 = 10;
	localparam int STEPS_8 = 8;
	localparam int CNT_W = 7;
	localparam logic [6:0] SHORT_SAMPLE_TICKS = 7'(SHORT_SAMPLE_HALF);
	localparam logic [6:0] LONG_SAMPLE_TICKS = 7'(LONG_SAMPLE_HALF);
	localparam logic [6:0] STEPS_10_TICKS = 7'(STEPS_10);
	localparam logic [6:0] STEPS_8_TICKS = 7'(STEPS_8);
	localparam logic [9:0] RESULT_RESET = 10'h000;
	typedef enum logic [2:0] {
		ALC_IDLE = 3'b001,
		ALC_SAMPLE = 3'b010,
		ALC_CONVERT = 3'b100
	} alc_state_t;
endpackage

// File: core/alc_sync.sv
/*
 two-flop synchroniser for a pin level.
 assumes the input may change at any time relative to clk_i.
*/
`timescale 1ns/1ps
module alc_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// level in and out
	input wire logic d_i,
	output logic q_o
);
	logic meta_reg, meta_next;
	logic q_reg, q_next;

	// first stage feeds only the second
	always_comb begin
		meta_next = d_i;
		q_next = meta_reg;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_reg <= 1'b0;
			q_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			q_reg <= q_next;
		end
	end

	assign q_o = q_reg;
endmodule

// File: core/alc_ctrl.sv
/*
 sequencer for the converter: sample window, approximation steps, result,
 done flag and interrupt, wait and stop behaviour.
 assumes converter_clock_tick_i is a one-cycle pulse at twice the converter
 clock rate (one per half cycle), and compare_i is the comparator answer
 for the current trial bit. bus-side strobes are single-cycle, same clock.
*/
`timescale 1ns/1ps
module alc_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// status and control write, with its fields, and the result low read
	input wire logic status_control_write_i,
	input wire logic [4:0] channel_select_field_i,
	input wire logic continuous_convert_bit_i,
	input wire logic completion_irq_enable_i,
	input wire logic long_sample_select_i,
	input wire logic hw_trigger_mode_select_i,
	input wire logic mode_10bit_i,
	input wire logic result_low_read_i,
	// power modes
	input wire logic stop_mode_i,
	input wire logic wait_mode_i,
	input wire logic async_clock_enable_i,
	// converter side
	input wire logic converter_clock_tick_i,
	input wire logic compare_i,
	input wire logic hw_trigger_i,
	// outputs
	output logic sampling_o,
	output logic converter_active_o,
	output logic [9:0] trial_code_o,
	output logic [9:0] result_o,
	output logic conversion_done_flag_o,
	output logic irq_o
);
	alc_pkg::alc_state_t state_reg, state_next;
	logic [6:0] cnt_reg, cnt_next;
	logic [9:0] sar_reg, sar_next;
	logic [9:0] result_reg, result_next;
	logic done_reg, done_next;
	logic irq_reg, irq_next;
	logic armed_reg, armed_next;
	logic trig_prev_reg, trig_prev_next;
	logic [4:0] chan_reg, chan_next;
	logic cont_reg, cont_next;
	logic ien_reg, ien_next;
	logic lsmp_reg, lsmp_next;
	logic hwt_reg, hwt_next;
	logic m10_reg, m10_next;
	logic trig_sync;
	logic stop_abort;
	logic trig_rise;
	logic [3:0] bit_idx;
	logic finish;

	// external trigger comes from a pin
	alc_sync u_trig_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i(hw_trigger_i),
		.q_o(trig_sync)
	);

	// wait_mode_i needs no logic: operation simply continues through wait
	assign stop_abort = stop_mode_i && !async_clock_enable_i; // R8
	assign trig_rise = trig_sync && !trig_prev_reg;
	assign bit_idx = 4'(cnt_reg) - 4'h1;

	// next-state logic for the sequencer and its registers
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sar_next = sar_reg;
		result_next = result_reg;
		done_next = done_reg;
		irq_next = irq_reg;
		armed_next = armed_reg;
		trig_prev_next = trig_sync;
		chan_next = chan_reg;
		cont_next = cont_reg;
		ien_next = ien_reg;
		lsmp_next = lsmp_reg;
		hwt_next = hwt_reg;
		m10_next = m10_reg;
		finish = 1'b0;
		if (result_low_read_i) begin
			done_next = 1'b0; // R15
			irq_next = 1'b0; // R18
		end
		unique case (state_reg)
			alc_pkg::ALC_IDLE: begin
				// hardware trigger starts a conversion when armed
				if (hwt_reg && armed_reg && trig_rise) begin // R13
					state_next = alc_pkg::ALC_SAMPLE;
					cnt_next = lsmp_reg ? alc_pkg::LONG_SAMPLE_TICKS
						: alc_pkg::SHORT_SAMPLE_TICKS;
				end
			end
			alc_pkg::ALC_SAMPLE: begin
				// window counted in half cycles to reach the .5 figure
				if (converter_clock_tick_i) begin
					if (cnt_reg == 7'h01) begin // R1 R2
						state_next = alc_pkg::ALC_CONVERT;
						cnt_next = m10_reg ? alc_pkg::STEPS_10_TICKS
							: alc_pkg::STEPS_8_TICKS;
						sar_next = 10'h000;
					end else begin
						cnt_next = cnt_reg - 7'h01;
					end
				end
			end
			alc_pkg::ALC_CONVERT: begin
				// one trial bit per tick, msb first
				if (converter_clock_tick_i) begin
					sar_next[bit_idx] = compare_i;
					if (cnt_reg == 7'h01) begin
						finish = 1'b1;
					end else begin
						cnt_next = cnt_reg - 7'h01;
					end
				end
			end
			default: begin
				state_next = alc_pkg::ALC_IDLE;
			end
		endcase
		if (finish) begin
			// 8-bit result sits in the low bits, upper bits zero
			result_next = sar_next; // R3
			done_next = 1'b1; // R5 R6 R11
			irq_next = ien_reg; // R4
			if (cont_reg) begin // R17
				state_next = alc_pkg::ALC_SAMPLE;
				cnt_next = lsmp_reg ? alc_pkg::LONG_SAMPLE_TICKS
					: alc_pkg::SHORT_SAMPLE_TICKS;
			end else begin
				state_next = alc_pkg::ALC_IDLE; // R12
			end
		end
		if (stop_abort) begin
			// result left untouched; only a write re-arms
			state_next = alc_pkg::ALC_IDLE; // R8 R10
			armed_next = 1'b0; // R9
		end
		if (status_control_write_i) begin
			chan_next = channel_select_field_i;
			cont_next = continuous_convert_bit_i;
			ien_next = completion_irq_enable_i;
			lsmp_next = long_sample_select_i;
			hwt_next = hw_trigger_mode_select_i;
			m10_next = mode_10bit_i;
			done_next = 1'b0; // R15
			irq_next = 1'b0; // R18
			armed_next = (channel_select_field_i != alc_pkg::CHAN_OFF); // R9
			if (channel_select_field_i == alc_pkg::CHAN_OFF) begin
				state_next = alc_pkg::ALC_IDLE; // R7
			end else if (hw_trigger_mode_select_i) begin
				state_next = alc_pkg::ALC_IDLE; // R13
			end else begin
				state_next = alc_pkg::ALC_SAMPLE; // R16
				cnt_next = long_sample_select_i ? alc_pkg::LONG_SAMPLE_TICKS
					: alc_pkg::SHORT_SAMPLE_TICKS;
			end
		end
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= alc_pkg::ALC_IDLE;
			cnt_reg <= 7'h00;
			sar_reg <= 10'h000;
			result_reg <= alc_pkg::RESULT_RESET;
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
			armed_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			chan_reg <= alc_pkg::CHAN_OFF;
			cont_reg <= 1'b0;
			ien_reg <= 1'b0;
			lsmp_reg <= 1'b0;
			hwt_reg <= 1'b0;
			m10_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sar_reg <= sar_next;
			result_reg <= result_next;
			done_reg <= done_next;
			irq_reg <= irq_next;
			armed_reg <= armed_next;
			trig_prev_reg <= trig_prev_next;
			chan_reg <= chan_next;
			cont_reg <= cont_next;
			ien_reg <= ien_next;
			lsmp_reg <= lsmp_next;
			hwt_reg <= hwt_next;
			m10_reg <= m10_next;
		end
	end

	// converter power follows the sequencer state
	logic samp_o_reg, act_o_reg;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			samp_o_reg <= 1'b0;
			act_o_reg <= 1'b0;
		end else begin
			samp_o_reg <= (state_next == alc_pkg::ALC_SAMPLE);
			act_o_reg <= (state_next != alc_pkg::ALC_IDLE); // R7 R12
		end
	end

	assign sampling_o = samp_o_reg;
	assign converter_active_o = act_o_reg;
	assign trial_code_o = sar_reg;
	assign result_o = result_reg;
	assign conversion_done_flag_o = done_reg;
	assign irq_o = irq_reg;
endmodule

// File: tb/alc_ctrl_props.sv
/* port checker for the converter sequencer.
 assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module alc_ctrl_props (
	// inputs watched
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic status_control_write_i,
	input wire logic [4:0] channel_select_field_i,
	input wire logic long_sample_select_i,
	input wire logic hw_trigger_mode_select_i,
	input wire logic result_low_read_i,
	input wire logic stop_mode_i,
	input wire logic async_clock_enable_i,
	input wire logic converter_clock_tick_i,
	// outputs watched
	input wire logic sampling_o,
	input wire logic converter_active_o,
	input wire logic [9:0] result_o,
	input wire logic conversion_done_flag_o,
	input wire logic irq_o
);
	logic [6:0] cnt_reg, cnt_next;
	logic long_reg, long_next, halt;
	// ticks in the open window; a write restarts the count
	always_comb begin
		halt = stop_mode_i && !async_clock_enable_i;
		cnt_next = sampling_o ? cnt_reg + 7'(converter_clock_tick_i) : 7'h00;
		if (status_control_write_i) cnt_next = 7'h00;
		long_next = status_control_write_i ? long_sample_select_i : long_reg;
	end
	always_ff @(posedge clk_i) begin
		cnt_reg <= reset_i ? 7'h00 : cnt_next;
		long_reg <= reset_i ? 1'b0 : long_next;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// a write or a stop cuts the window short, so only natural ends are timed
	win_len_a: assert property ($fell(sampling_o) && !$past(halt) && !$past(status_control_write_i)
		|-> cnt_reg == (long_reg ? 7'h2F : 7'h07)) else $error("window length wrong");
	irq_rise_a: assert property ($rose(irq_o) |-> $rose(conversion_done_flag_o))
		else $error("irq without completion");
	write_clears_a: assert property (status_control_write_i |=> !conversion_done_flag_o
		&& !irq_o) else $error("write left flag set");
	flag_fall_a: assert property ($fell(conversion_done_flag_o) |->
		$past(status_control_write_i) || $past(result_low_read_i)) else $error("flag lost");
	off_idle_a: assert property (status_control_write_i && channel_select_field_i == 5'h1F
		|=> !converter_active_o && !sampling_o) else $error("all ones did not idle");
	write_start_a: assert property (status_control_write_i && !halt
		&& channel_select_field_i != 5'h1F && !hw_trigger_mode_select_i
		|=> sampling_o && converter_active_o) else $error("write did not start");
	stop_abort_a: assert property (halt && !status_control_write_i |=> !converter_active_o)
		else $error("stop did not abort");
	result_hold_a: assert property ($changed(result_o) |-> conversion_done_flag_o
		|| $past(status_control_write_i)) else $error("result changed early");
	cover property ($rose(irq_o));
	cover property ($fell(sampling_o) && long_reg);
	cover property (halt && $past(converter_active_o));
endmodule
bind alc_ctrl alc_ctrl_props u_props (.*);

// File: tb/testbench.sv
/* self-checking bench for the converter sequencer.
 assumes 20 MHz clock; the bench makes converter ticks. */
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stp = 1'b0, wt = 1'b0, ac = 1'b0;
	logic co = 1'b0, ie = 1'b0, ls = 1'b0, hw = 1'b0, m10 = 1'b0, tick = 1'b0, cmp = 1'b0;
	logic trig = 1'b0, smp, act, done, irq;
	logic [4:0] ch = 5'h1F;
	logic [9:0] trial, res;
	int error_cnt = 0, comparisons = 0;
	always #25 clk = ~clk;
	// one tick every second cycle
	always @(posedge clk) tick <= #1 ~tick;
	alc_ctrl dut (.clk_i(clk), .reset_i(rst), .status_control_write_i(wr),
		.channel_select_field_i(ch), .continuous_convert_bit_i(co), .completion_irq_enable_i(ie),
		.long_sample_select_i(ls), .hw_trigger_mode_select_i(hw), .mode_10bit_i(m10),
		.result_low_read_i(rd), .stop_mode_i(stp), .wait_mode_i(wt), .async_clock_enable_i(ac),
		.converter_clock_tick_i(tick), .compare_i(cmp), .hw_trigger_i(trig), .sampling_o(smp),
		.converter_active_o(act), .trial_code_o(trial), .result_o(res),
		.conversion_done_flag_o(done), .irq_o(irq));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// control write; f is {continuous, irq enable, long, hw mode, 10-bit}
	task automatic ctl(input logic [4:0] c, input logic [4:0] f);
		ch = c;
		{co, ie, ls, hw, m10} = f;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// bounded wait for the done flag
	task automatic wait_done();
		int i;
		for (i = 0; i < 300 && done !== 1'b1; i++) step(1);
		if (i == 300) begin
			error_cnt++;
			$display("ERROR %0t no completion", $time);
			complete_run();
		end
	endtask
	// bounded wait for the first trial bit after the window closes
	task automatic wait_trial();
		int i;
		for (i = 0; i < 300 && !(smp === 1'b0 && trial !== 10'h000); i++) step(1);
		if (i == 300) begin
			error_cnt++;
			$display("ERROR %0t no trial bit", $time);
			complete_run();
		end
	endtask
	initial begin
		step(5);
		rst = 1'b0;
		cmp = 1'b1;
		ctl(5'h00, 5'b01001);
		chk(10'({smp, act}), 10'h003);
		wait_done();
		chk(res, 10'h3FF);
		chk(trial, 10'h3FF);
		chk(10'(irq), 10'h001);
		chk(10'(act), 10'h000);
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk(10'({done, irq}), 10'h000);
		$display("test single done");
		// 8-bit long window: first trial bit must be bit 7, then comparator goes low
		ctl(5'h03, 5'b00100);
		wait_trial();
		chk(trial, 10'h080);
		cmp = 1'b0;
		wait_done();
		chk(res, 10'h080);
		chk(10'({done, irq}), 10'h002);
		$display("test long done");
		// hardware-triggered continuous run, cut by stop with async clock off
		cmp = 1'b1;
		ctl(5'h01, 5'b11011);
		trig = 1'b1;
		step(4);
		trig = 1'b0;
		wait_done();
		step(4);
		chk(10'(act), 10'h001);
		stp = 1'b1;
		step(2);
		chk(10'(act), 10'h000);
		chk(res, 10'h3FF);
		stp = 1'b0;
		// a trigger after stop must not restart without a write
		trig = 1'b1;
		step(4);
		trig = 1'b0;
		step(40);
		chk(10'(act), 10'h000);
		ctl(5'h1F, 5'b10001);
		step(40);
		chk(10'({act, done}), 10'h000);
		$display("test stop done");
		ac = 1'b1;
		wt = 1'b1;
		ctl(5'h02, 5'b01001);
		stp = 1'b1;
		wait_done();
		chk(10'(irq), 10'h001);
		ctl(5'h02, 5'b01011);
		step(20);
		chk(10'(act), 10'h000);
		trig = 1'b1;
		step(4);
		trig = 1'b0;
		wait_done();
		chk(10'(irq), 10'h001);
		$display("test trigger done");
		complete_run();
	end
endmodule
